// [ftd_consts.vh]
// Purpose: Constants for the FSK telegram decoder
// Assumes: 50 MHz mclk_i, byte addresses on a 32-bit Avalon-MM slave
// Notes:   Definitions only
`ifndef FTD_CONSTS_VH
`define FTD_CONSTS_VH

// Register byte addresses
`define FTD_ADDR_CTRL      4'h0
`define FTD_ADDR_MATCH     4'h4
`define FTD_ADDR_STATUS    4'h8

// Control register field positions
`define FTD_CTRL_KEYSEL    0
`define FTD_CTRL_DMGR      1
`define FTD_CTRL_SYNCW     2
`define FTD_CTRL_WAKE      3
`define FTD_CTRL_RATIO_LSB 4
`define FTD_CTRL_RATIO_MSB 5

// Power-on configuration: raw output, oscillator on, ratio code 01
`define FTD_RST_KEYSEL     1'b0
`define FTD_RST_DMGR       1'b0
`define FTD_RST_SYNCW      1'b0
`define FTD_RST_WAKE       1'b1
`define FTD_RST_RATIO      2'h1
`define FTD_RST_MATCH      8'h00

// Framing word 0110 as half-bit pairs, and its complement
`define FTD_SYNC_TRUE      8'h69
`define FTD_SYNC_INV       8'h96

// Timing
`define FTD_CLK_MHZ        50
`define FTD_SETTLE_US      1000
`define FTD_HALF_CYC       1250
`define FTD_STROBE_CYC     50000

`endif

// [ftd_decoder.v]
// Purpose: Manchester FSK telegram decoder with duty-cycle timer and Avalon-MM registers
// Assumes: rx_data_i and run_request_i are synchronous to mclk_i
// Notes:   Bit rate is fixed by HALF_CYC; the recovered clock resyncs on every edge
`timescale 1ns/1ps
`default_nettype none
`include "ftd_consts.vh"

// Operation
// [R1] Manchester: true half then inverse half
// [R2] Transmitter keeps duty cycle 45 to 55 percent
// [R3] Bit clock recovered from stream transitions
// [R4] Decoding only with data manager and FSK
// [R5] Match word equals register or its complement
// [R6] Match word sent at payload bit rate
// [R7] Preamble precedes match word and framing/payload
// [R8] Preamble never mimics match or framing word
// [R9] Framing word 0110 or its complement
// [R10] Payload follows framing word without gap
// [R11] Two equal NRZ bit periods end message
// [R12] Transmitter always sends end-of-message pattern
// [R13] Complemented framing word inverts payload output
// [R14] Duty cycling stays in run after match
// [R15] Match burst spans two run slots
// [R16] Sleep ratio periods, then one run period
// [R17] External run request obeys same timing
// [R18] Run request forces run mode always
// [R19] Configuration kept during sleep
// [R20] Raw data unless data manager enabled
// [R21] Power-on default allows standalone reception
// [R22] Ignore data for 1 ms after waking
// [R23] Ratio codes select 3, 7, 15, 31
// [R24] Payload on data line, clock on clock line
// [R25] Pad last byte of partial payload
// [R26] After end of message, search again
module ftd_decoder #(
   parameter HALF_CYC   = `FTD_HALF_CYC,
   parameter STROBE_CYC = `FTD_STROBE_CYC,
   parameter SETTLE_CYC = `FTD_SETTLE_US * `FTD_CLK_MHZ
) (
   // Clock and reset
   input  wire        mclk_i,
   input  wire        reset_n_i,
   // Receiver side
   input  wire        rx_data_i,
   input  wire        run_request_i,
   // Serial output to the microcontroller
   output wire        data_out_o,
   output wire        sclk_o,
   output wire        run_o,
   // Avalon-MM slave
   input  wire [3:0]  address_i,
   input  wire        read_i,
   input  wire        write_i,
   input  wire [31:0] writedata_i,
   output wire [31:0] readdata_o,
   output wire        waitrequest_o
);

   localparam [3:0] ST_SEARCH = 4'h1;
   localparam [3:0] ST_SYNCW  = 4'h2;
   localparam [3:0] ST_DATA   = 4'h4;
   localparam [3:0] ST_PAD    = 4'h8;

   // Decodes 8 Manchester bits from 16 half-bit samples; bit 8 flags validity
   function [8:0] ftd_mdec;
      input [15:0] h;
      integer i;
      begin
         ftd_mdec = {1'b1, 8'h00};
         for (i = 0; i < 8; i = i + 1) begin
            ftd_mdec[i] = h[2*i+1];
            if (h[2*i+1] == h[2*i])
               ftd_mdec[8] = 1'b0;
         end
      end
   endfunction

   // Sleep ratio from the two-bit code: (4 << code) - 1
   function [4:0] ftd_ratio;
      input [1:0] code;
      begin
         ftd_ratio = {&code, code[1], |code, 2'h3};
      end
   endfunction

   reg        keying_select_r;
   reg        data_manager_enable_r;
   reg        sync_word_present_r;
   reg        wake_osc_enable_r;
   reg [1:0]  sleep_ratio_r;
   reg [7:0]  match_word_register_r;
   reg        waitreq_r;
   reg [31:0] rdata_r;
   reg        rx_d_r;
   reg [31:0] ph_r;
   reg [15:0] hs_r;
   reg        bit_ph_r;
   reg [3:0]  state_r;
   reg        inv_r;
   reg        nrz_r;
   reg        nrz_lvl_r;
   reg [2:0]  bit_cnt_r;
   reg [31:0] pad_tmr_r;
   reg        dout_r;
   reg        sclk_r;
   reg [31:0] sck_cnt_r;
   reg [31:0] strobe_tmr_r;
   reg [4:0]  slot_r;
   reg        keep_r;
   reg        run_r;
   reg [31:0] settle_r;
   reg        end_of_message_r;

   wire        req      = read_i | write_i;
   wire        dm_on    = data_manager_enable_r & keying_select_r;
   wire        half_ev  = (ph_r == HALF_CYC / 2);
   wire [15:0] hw       = {hs_r[14:0], rx_data_i};
   wire [8:0]  mdec     = ftd_mdec(hw);
   wire        bit_end  = half_ev & bit_ph_r;
   wire        armed    = dm_on & run_r & (settle_r == 32'h0);
   wire        timer_run = wake_osc_enable_r & (slot_r == ftd_ratio(sleep_ratio_r));
   wire        run_nxt  = run_request_i | timer_run | keep_r;
   wire        pad_ev   = (pad_tmr_r == 2 * HALF_CYC - 1);
   reg         emit;
   reg         emit_bit;

   // Bus slave: one wait cycle, read data loaded on the same edge waitrequest drops
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         waitreq_r             <= 1'b1;
         rdata_r               <= 32'h0;
         keying_select_r       <= `FTD_RST_KEYSEL;    // [R21]
         data_manager_enable_r <= `FTD_RST_DMGR;
         sync_word_present_r   <= `FTD_RST_SYNCW;
         wake_osc_enable_r     <= `FTD_RST_WAKE;
         sleep_ratio_r         <= `FTD_RST_RATIO;
         match_word_register_r <= `FTD_RST_MATCH;
      end else begin
         waitreq_r <= ~(req & waitreq_r);
         if (read_i & waitreq_r) begin
            case (address_i)
               `FTD_ADDR_CTRL:   rdata_r <= {26'h0, sleep_ratio_r, wake_osc_enable_r,
                                             sync_word_present_r, data_manager_enable_r,
                                             keying_select_r};
               `FTD_ADDR_MATCH:  rdata_r <= {24'h0, match_word_register_r};
               `FTD_ADDR_STATUS: rdata_r <= {27'h0, end_of_message_r, inv_r, keep_r,
                                             (state_r != ST_SEARCH), run_r};
               default:          rdata_r <= 32'h0;
            endcase
         end
         // Writes land on the accepting edge; sleep never touches these [R19]
         if (write_i & ~waitreq_r) begin
            if (address_i == `FTD_ADDR_CTRL) begin
               keying_select_r       <= writedata_i[`FTD_CTRL_KEYSEL];
               data_manager_enable_r <= writedata_i[`FTD_CTRL_DMGR];
               sync_word_present_r   <= writedata_i[`FTD_CTRL_SYNCW];
               wake_osc_enable_r     <= writedata_i[`FTD_CTRL_WAKE];
               sleep_ratio_r         <= writedata_i[`FTD_CTRL_RATIO_MSB:`FTD_CTRL_RATIO_LSB];
            end else if (address_i == `FTD_ADDR_MATCH) begin
               match_word_register_r <= writedata_i[7:0];
            end
         end
      end
   end

   // Sleep/run timer: ratio slots asleep then one slot in run
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         strobe_tmr_r <= 32'h0;
         slot_r       <= 5'h0;
         run_r        <= 1'b0;
         settle_r     <= 32'h0;
      end else begin
         run_r <= run_nxt;                                    // [R18] [R14]
         if (strobe_tmr_r == STROBE_CYC - 1) begin
            strobe_tmr_r <= 32'h0;
            if (slot_r >= ftd_ratio(sleep_ratio_r))          // [R16] [R23]
               slot_r <= 5'h0;
            else
               slot_r <= slot_r + 5'h1;
         end else begin
            strobe_tmr_r <= strobe_tmr_r + 32'h1;
         end
         // Settling window restarts on every wake-up
         if (run_nxt & ~run_r)
            settle_r <= SETTLE_CYC;                           // [R22]
         else if (settle_r != 32'h0)
            settle_r <= settle_r - 32'h1;
      end
   end

   // Half-bit phase tracking; each transition pulls the phase back to zero
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         rx_d_r <= 1'b0;
         ph_r   <= 32'h0;
         hs_r   <= 16'h0;
      end else begin
         rx_d_r <= rx_data_i;
         if ((rx_data_i != rx_d_r) | (ph_r == HALF_CYC - 1))
            ph_r <= 32'h0;                                    // [R3]
         else
            ph_r <= ph_r + 32'h1;
         if (half_ev)
            hs_r <= hw;
      end
   end

   // Payload bit selection for the output stage
   always @* begin
      emit     = 1'b0;
      emit_bit = 1'b0;
      if (state_r == ST_DATA && bit_end && armed && hw[1] != hw[0]) begin
         emit     = 1'b1;
         emit_bit = hw[1] ^ inv_r;                            // [R1] [R13]
      end else if (state_r == ST_PAD && pad_ev) begin
         emit     = 1'b1;
      end
   end

   // Telegram state machine
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         state_r    <= ST_SEARCH;
         bit_ph_r   <= 1'b0;
         inv_r      <= 1'b0;
         nrz_r      <= 1'b0;
         nrz_lvl_r  <= 1'b0;
         keep_r     <= 1'b0;
         pad_tmr_r  <= 32'h0;
         end_of_message_r <= 1'b0;
      end else if (!armed && state_r != ST_PAD) begin
         state_r  <= ST_SEARCH;                               // [R4]
         bit_ph_r <= 1'b0;
         nrz_r    <= 1'b0;
         keep_r   <= keep_r & dm_on & run_r;
      end else begin
         if (half_ev)
            bit_ph_r <= ~bit_ph_r;
         pad_tmr_r <= pad_ev ? 32'h0 : pad_tmr_r + 32'h1;
         case (state_r)
            ST_SEARCH: begin
               if (half_ev && mdec[8] && (mdec[7:0] == match_word_register_r ||
                   mdec[7:0] == ~match_word_register_r)) begin   // [R5]
                  bit_ph_r   <= 1'b0;
                  inv_r      <= 1'b0;
                  nrz_r      <= 1'b0;
                  keep_r     <= 1'b1;                          // [R14]
                  end_of_message_r <= 1'b0;
                  state_r    <= sync_word_present_r ? ST_SYNCW : ST_DATA;
               end
            end
            ST_SYNCW: begin
               if (bit_end && hw[7:0] == `FTD_SYNC_TRUE) begin  // [R9]
                  inv_r   <= 1'b0;
                  state_r <= ST_DATA;                         // [R10]
               end else if (bit_end && hw[7:0] == `FTD_SYNC_INV) begin
                  inv_r   <= 1'b1;                            // [R13]
                  state_r <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (bit_end) begin
                  if (hw[1] != hw[0]) begin
                     nrz_r <= 1'b0;
                  end else if (nrz_r && nrz_lvl_r == hw[1]) begin
                     end_of_message_r <= 1'b1;                // [R11]
                     keep_r     <= 1'b0;
                     nrz_r      <= 1'b0;
                     pad_tmr_r  <= 32'h0;
                     state_r    <= (bit_cnt_r != 3'h0) ? ST_PAD : ST_SEARCH;  // [R26]
                  end else begin
                     nrz_r     <= 1'b1;
                     nrz_lvl_r <= hw[1];
                  end
               end
            end
            ST_PAD: begin
               if (pad_ev && bit_cnt_r == 3'h7)
                  state_r <= ST_SEARCH;                       // [R25] [R26]
            end
            default: state_r <= ST_SEARCH;
         endcase
      end
   end

   // Output stage: a high clock pulse of one half-bit per emitted bit
   always @(posedge mclk_i) begin
      if (!reset_n_i) begin
         dout_r    <= 1'b0;
         sclk_r    <= 1'b0;
         sck_cnt_r <= 32'h0;
         bit_cnt_r <= 3'h0;
      end else if (!dm_on) begin
         dout_r    <= rx_data_i;                              // [R20]
         sclk_r    <= 1'b0;
         sck_cnt_r <= 32'h0;
         bit_cnt_r <= 3'h0;
      end else if (emit) begin
         dout_r    <= emit_bit;                               // [R24]
         sclk_r    <= 1'b1;
         sck_cnt_r <= HALF_CYC - 1;
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end else if (sck_cnt_r != 32'h0) begin
         sck_cnt_r <= sck_cnt_r - 32'h1;
      end else begin
         sclk_r <= 1'b0;
         if (state_r == ST_SEARCH) begin
            dout_r    <= 1'b0;
            bit_cnt_r <= 3'h0;                                // Drop a byte cut short by sleep
         end
      end
   end

   assign data_out_o    = dout_r;
   assign sclk_o        = sclk_r;
   assign run_o         = run_r;
   assign readdata_o    = rdata_r;
   assign waitrequest_o = waitreq_r;

endmodule // ftd_decoder
`default_nettype wire

// [ftd_decoder_asserts.sv]
// Purpose: Port checks for the FSK telegram decoder
// Assumes: Decoder built with a half bit of 8 cycles
// Notes:   Follows the data manager bit from accepted bus writes
`timescale 1ns/1ps
`default_nettype none
module ftd_decoder_chk #(parameter HALF_CYC = 8) (
   // Clock and reset
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   // Link and timer
   input wire logic        rx_data_i,
   input wire logic        run_request_i,
   input wire logic        data_out_o,
   input wire logic        sclk_o,
   input wire logic        run_o,
   // Register bus
   input wire logic [3:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o
);
   logic dmgr_r;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Mirror of the data manager bit; a write lands at the accepting edge
   always_ff @(posedge mclk_i)
      if (!reset_n_i) dmgr_r <= 1'b0;
      else if (write_i && !waitrequest_o && address_i == 4'h0) dmgr_r <= writedata_i[1];
   property p_force; run_request_i |=> run_o; endproperty
   a_force: assert property (p_force) else $error("run request did not force run");
   property p_raw;
      !dmgr_r && !$past(dmgr_r) && $past(reset_n_i) |-> data_out_o == $past(rx_data_i);
   endproperty
   a_raw: assert property (p_raw) else $error("raw output does not follow line");
   property p_noclk; !dmgr_r && !$past(dmgr_r) |-> !sclk_o; endproperty
   a_noclk: assert property (p_noclk) else $error("clock seen in raw mode");
   property p_wait; (read_i || write_i) && waitrequest_o |=> !waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("bus request not answered");
   property p_one; !waitrequest_o |=> waitrequest_o; endproperty
   a_one: assert property (p_one) else $error("waitrequest low too long");
   property p_unmap; read_i && !waitrequest_o && address_i == 4'hc |-> readdata_o == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   // Each payload bit gives a clock pulse of one half bit
   property p_pulse; $rose(sclk_o) |-> sclk_o[*8] ##1 !sclk_o; endproperty
   a_pulse: assert property (p_pulse) else $error("bit clock pulse length wrong");
   property p_settle; $rose(run_o) |-> !sclk_o[*8]; endproperty
   a_settle: assert property (p_settle) else $error("output before settling");
   c_bit: cover property ($rose(sclk_o));
   c_run: cover property ($rose(run_o));
   c_rd: cover property (read_i && !waitrequest_o);
endmodule // ftd_decoder_chk
bind ftd_decoder ftd_decoder_chk #(.HALF_CYC(HALF_CYC)) u_chk (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .rx_data_i(rx_data_i),
   .run_request_i(run_request_i), .data_out_o(data_out_o), .sclk_o(sclk_o),
   .run_o(run_o), .address_i(address_i), .read_i(read_i), .write_i(write_i),
   .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o));
`default_nettype wire

// [ftd_tx_model.sv]
// Purpose: Remote transmitter sending Manchester telegrams
// Assumes: send is called right after a rising edge of mclk_i
// Notes:   The line falls back low between frames
`timescale 1ns/1ps
`default_nettype none
module ftd_tx_model #(parameter int HALF = 8) (
   // Clock
   input  wire logic mclk_i,
   // Line to the receiver
   output var logic  rx_o
);
   initial rx_o = 1'b0;
   // Equal halves keep the duty cycle at 50 percent
   task automatic half(input logic b);
      rx_o <= b;
      repeat (HALF) @(posedge mclk_i);
   endtask
   task automatic mbit(input logic b);
      half(b);
      half(~b);
   endtask
   // A preamble of ones holds neither 0110 nor a match word
   task automatic send(input logic [7:0] mw, input logic inv, input logic [7:0] pl,
                       input int n);
      int i;
      logic [3:0] fw;
      fw = 4'h6 ^ {4{inv}};
      for (i = 0; i < 8; i++) mbit(1'b1);
      // Two match words in a row stretch the burst over the run slots
      for (i = 15; i >= 0; i--) mbit(mw[i % 8]);
      // Repeating the last match bit keeps 0110 and 1001 out of the join
      for (i = 0; i < 8; i++) mbit(mw[0]);
      for (i = 3; i >= 0; i--) mbit(fw[i]);
      for (i = 0; i < n; i++) mbit(pl[7 - i]);
      repeat (4) half(1'b1);
      rx_o <= 1'b0;
   endtask
endmodule // ftd_tx_model
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the FSK telegram decoder
// Assumes: Half bit 8, slot 64 and settling 16 cycles
// Notes:   One task per scenario; the transmitter model drives the line
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i, sclk_q = 1'b0, reset_n_i = 1'b0, run_request_i = 1'b0;
   logic        read_i = 1'b0, write_i = 1'b0, rx_line;
   logic [3:0]  address_i = 4'h0;
   logic [31:0] writedata_i = 32'h0, rd_v;
   logic [7:0]  got_b = 8'h0;
   wire         data_out_o, sclk_o, run_o, waitrequest_o;
   wire  [31:0] readdata_o;
   int          bad_count, n_tests, got_n, cyc;
   ftd_decoder #(.HALF_CYC(8), .STROBE_CYC(64), .SETTLE_CYC(16)) u_dut (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .rx_data_i(rx_line),
      .run_request_i(run_request_i), .data_out_o(data_out_o), .sclk_o(sclk_o),
      .run_o(run_o), .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o));
   ftd_tx_model #(.HALF(8)) u_tx (.mclk_i(mclk_i), .rx_o(rx_line));
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   // Shift in one bit per clock pulse; the ceiling cuts a hang short
   always @(posedge mclk_i) begin
      if (sclk_o && !sclk_q) begin
         got_b <= {got_b[6:0], data_out_o};
         got_n <= got_n + 1;
      end
      sclk_q <= sclk_o;
      cyc <= cyc + 1;
      if (cyc == 30000)
         give_verdict();
   end
   // Request held until waitrequest is seen low, released after
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      read_i <= !wr;
      write_i <= wr;
      address_i <= a;
      writedata_i <= d;
      do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
      rd_v = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // A run that reaches the ceiling counts as one more mismatch
   task automatic give_verdict;
      int nb;
      nb = bad_count + ((cyc >= 30000) ? 1 : 0);
      $display("checks %0d mismatches %0d", n_tests, nb);
      if (nb == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_regs;
      bus(0, 4'h0, 32'h0);
      chk("ctrl reset", 32'h18, rd_v);
      bus(0, 4'h4, 32'h0);
      chk("match reset", 32'h0, rd_v);
      bus(1, 4'hc, 32'hff);
      bus(0, 4'hc, 32'h0);
      chk("unmapped", 32'h0, rd_v);
      bus(1, 4'h4, 32'h1c3);
      bus(0, 4'h4, 32'h0);
      chk("match word", 32'hc3, rd_v);
      $display("test regs done");
   endtask
   // Send one telegram, then judge count and value of the bits out
   task automatic msg(input string nm, input logic [7:0] mw, input logic inv,
                      input logic [7:0] pl, input int n, input logic [7:0] eb, input int en);
      int n0;
      n0 = got_n;
      u_tx.send(mw, inv, pl, n);
      repeat (300) @(posedge mclk_i);
      chk(nm, en, got_n - n0);
      if (en > 0) chk(nm, eb, got_b);
   endtask
   task automatic t_raw;
      msg("raw pulses", 8'hc3, 1'b0, 8'hb0, 5, 8'h0, 0);
      $display("test raw done");
   endtask
   // Sleep and run lengths for every ratio code
   task automatic t_timer;
      int c, hi, lo;
      for (c = 0; c < 4; c++) begin
         bus(1, 4'h0, 32'h8 | (c << 4));
         while (run_o !== 1'b0) @(posedge mclk_i);
         while (run_o !== 1'b1) @(posedge mclk_i);
         hi = 0;
         lo = 0;
         while (run_o === 1'b1) begin
            @(posedge mclk_i);
            hi++;
         end
         while (run_o === 1'b0) begin
            @(posedge mclk_i);
            lo++;
         end
         chk("run slot", 64, hi);
         chk("sleep time", ((4 << c) - 1) * 64, lo);
         bus(0, 4'h0, 32'h0);
         chk("ctrl kept", 32'h8 | (c << 4), rd_v);
      end
      $display("test timer done");
   endtask
   task automatic t_force;
      bus(1, 4'h0, 32'h0);
      repeat (4) @(posedge mclk_i);
      chk("run idle", 32'h0, run_o);
      // Held high for the rest of the run, longer than any run slot
      run_request_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk("run forced", 32'h1, run_o);
      $display("test force done");
   endtask
   task automatic t_msgs;
      bus(1, 4'h0, 32'h7);
      repeat (40) @(posedge mclk_i);
      msg("true frame", 8'hc3, 1'b0, 8'hb0, 5, 8'hb0, 8);
      bus(0, 4'h8, 32'h0);
      chk("status end", 32'h10, rd_v & 32'h12);
      msg("inverted frame", 8'h3c, 1'b1, 8'h5a, 8, 8'ha5, 8);
      msg("wrong word", 8'h81, 1'b0, 8'hff, 8, 8'h0, 0);
      bus(1, 4'h0, 32'h6);
      msg("keying off", 8'hc3, 1'b0, 8'hb0, 5, 8'h0, 0);
      $display("test messages done");
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      t_regs();
      t_raw();
      t_timer();
      t_force();
      t_msgs();
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
